/* File: core/fpc_cfg.svh */
// opcodes, field positions, reset values and timing figures of the password/reset command block
// assumes a 20 MHz core clock; included by bare name wherever a figure is needed
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH

`define FPC_CLK_MHZ 20
`define FPC_OP_WR_EN 8'h06
`define FPC_OP_CLR_STAT 8'h30
`define FPC_OP_PW_PROG 8'he8
`define FPC_OP_PW_UNLOCK 8'he9
`define FPC_OP_SW_RST 8'hf0
`define FPC_OP_MODE_RST 8'hff
`define FPC_OP_PGM_SUSP 8'h85
`define FPC_OP_PGM_RES 8'h8a
`define FPC_OP_ERS_SUSP 8'h75
`define FPC_OP_ERS_RES 8'h7a
`define FPC_OP_BITS 7'h08
`define FPC_FRAME_BITS 7'h48
`define FPC_SPC_PW_MODE 2
`define FPC_CFG_BP_VOL 3
`define FPC_PW_RST 64'hffff_ffff_ffff_ffff
`define FPC_T_PSL_US 40
`define FPC_T_ESL_US 45
`define FPC_T_PP_US 1300
`define FPC_T_SE_MS 2600
`define FPC_PSL_CYC (`FPC_T_PSL_US * `FPC_CLK_MHZ)
`define FPC_ESL_CYC (`FPC_T_ESL_US * `FPC_CLK_MHZ)
`define FPC_PP_CYC (`FPC_T_PP_US * `FPC_CLK_MHZ)
`define FPC_SE_CYC (`FPC_T_SE_MS * 1000 * `FPC_CLK_MHZ)

`endif

/* File: core/fpc_pkg.sv */
// types shared by the password/reset command block
// assumes nothing beyond a SystemVerilog compiler
package fpc_pkg;
    // one-hot operation states
    typedef enum logic [7:0] {
        st_idle = 8'h01,
        st_pwprog = 8'h02,
        st_unlock = 8'h04,
        st_unlock_fail = 8'h08,
        st_recover = 8'h10,
        st_program = 8'h20,
        st_erase = 8'h40,
        st_suspend = 8'h80
    } fpc_state_t;
    // link-side shifter contents
    typedef struct packed {
        logic [6:0] cnt;
        logic [7:0] op;
        logic [63:0] pw;
    } fpc_rx_t;
    // core-side state
    typedef struct packed {
        fpc_state_t st;
        logic wen;
        logic perr;
        logic eerr;
        logic lock;
        logic frz;
        logic crd;
        logic psusp;
        logic esusp;
        logic is_ers;
        logic match;
        logic [2:0] bp;
        logic [63:0] pw;
        logic [25:0] rem;
        logic cs_m;
        logic cs_s;
        logic cs_p;
        logic hr_m;
        logic hr_s;
    } fpc_core_t;
endpackage : fpc_pkg

/* File: core/fpc_link_if.sv */
// carrier between the serial-clock shifter and the core command logic
// assumes words are only read while chip select is high and the serial clock stands still
`timescale 1ns/1ps
`default_nettype none
interface fpc_link_if;
    logic [7:0] opcode; // first byte of the frame
    logic [6:0] nbits; // bits seen, saturating
    logic [63:0] pw; // password, byte-reordered
    modport rx (output opcode, output nbits, output pw);
    modport core (input opcode, input nbits, input pw);
endinterface : fpc_link_if
`default_nettype wire

/* File: core/fpc_link_rx.sv */
// serial input shifter running on the host's serial clock
// assumes mode 0/3 sampling on the rising edge and a stopped clock while chip select is high
`timescale 1ns/1ps
`default_nettype none
`include "fpc_cfg.svh"
module fpc_link_rx
    import fpc_pkg::*;
(
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    fpc_link_if.rx lnk
);
    fpc_rx_t q, d;
    logic fresh_q; // next edge is the first of a frame
    logic [5:0] n;

    // frame start marker; chip select itself sets it, so no edge is needed outside a frame
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // shift: opcode msb first, then password bytes lsb first, bits msb first
    always_comb begin
        d = q;
        n = 6'(q.cnt - `FPC_OP_BITS);
        if (fresh_q) begin
            d.cnt = 7'h01;
            d.op = {7'h00, si};
        end else begin
            if (q.cnt < `FPC_OP_BITS) begin
                d.op = {q.op[6:0], si};
            end else if (q.cnt < `FPC_FRAME_BITS) begin
                d.pw[{n[5:3], ~n[2:0]}] = si;
            end
            // saturate so an overlong frame never aliases to a valid length
            if (q.cnt != 7'h7f) begin
                d.cnt = q.cnt + 7'h01;
            end
        end
    end

    // words stay put after the last edge, which the core relies on
    always_ff @(posedge sck) begin
        q <= d;
    end

    assign lnk.opcode = q.op;
    assign lnk.nbits = q.cnt;
    assign lnk.pw = q.pw;
endmodule : fpc_link_rx
`default_nettype wire

/* File: core/fpc_timer.sv */
// down-counter for self-timed operations and suspend latencies
// assumes a load value of at least one; done is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module fpc_timer
    import fpc_pkg::*;
#(
    parameter int W = 26
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done,
    output logic [W-1:0] remaining
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } fpc_tmr_t;
    fpc_tmr_t q, d;

    // reload wins over counting
    always_comb begin
        d = q;
        if (load) begin
            d.cnt = value;
        end else if (q.cnt != '0) begin
            d.cnt = q.cnt - W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign done = (q.cnt == W'(1)) && !load;
    assign remaining = q.cnt;
endmodule : fpc_timer
`default_nettype wire

/* File: core/fpc_top.sv */
// command logic of a serial flash: password program/unlock, software and mode-bit reset,
// suspend latency and embedded program/erase busy timing
// assumes chip select stays high at least three core clocks between frames
// How it works
// - write-enable latch gates password program
// - password program ignored once password mode chosen
// - frame not exactly 72 bits is discarded
// - password program starts at select rise, busy
// - program error on fail; latch cleared after
// - unlock frame same order, exact length
// - valid unlock starts timed cycle, busy
// - mismatch: error set, busy stays set
// - clear-status, soft reset or pin recover
// - match sets protect lock bit
// - soft reset keeps freeze and lock bits
// - soft reset leaves nonvolatile config alone
// - soft reset clears volatile unfrozen protect bits
// - soft reset at select rise, then recovery
// - mode reset leaves continuous read mode
// - eight ones recognised even in continuous read
// - program suspend drops busy within 40 us
// - erase suspend drops busy within 45 us
// - sector erase busy, at most 2600 ms
// - clear-status clears failure flags, standby
`timescale 1ns/1ps
`default_nettype none
`include "fpc_cfg.svh"
module fpc_top
    import fpc_pkg::*;
#(
    parameter logic [25:0] PWPROG_CYC = 26'd2000,
    parameter logic [25:0] UNLOCK_CYC = 26'd2000,
    parameter logic [25:0] RECOVER_CYC = 26'd1000,
    parameter logic [25:0] PROGRAM_CYC = 26'(`FPC_PP_CYC),
    parameter logic [25:0] ERASE_CYC = 26'(`FPC_SE_CYC)
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hw_reset_pin_n,
    input wire logic [15:0] sector_protection_config_reg,
    input wire logic [7:0] config_reg_one,
    input wire logic [2:0] block_protect_nv,
    input wire logic op_fail,
    input wire logic prog_start,
    input wire logic erase_start,
    input wire logic cont_read_enter,
    input wire logic bp_wr,
    input wire logic [2:0] bp_wdata,
    input wire logic freeze_set,
    output logic busy_flag,
    output logic write_enable_latch,
    output logic program_error_flag,
    output logic erase_error_flag,
    output logic protect_lock_bit,
    output logic config_lock_bit,
    output logic [2:0] block_protect_bits,
    output logic cont_read_mode,
    output logic program_suspended,
    output logic erase_suspended
);
    fpc_core_t q, d;
    fpc_link_if lnk ();
    logic t_load; // timer reload strobe
    logic [25:0] t_val; // timer reload value
    logic t_done; // timer expired this cycle
    logic [25:0] t_rem; // cycles still to run
    logic cs_rise; // frame just ended
    logic len8; // frame was exactly one opcode
    logic len72; // frame was opcode plus password
    logic pw_mode; // password protection chosen
    logic bp_vol; // protect bits are volatile

    // serial-clock side
    fpc_link_rx u_rx (
        .sck(sck),
        .cs_n(cs_n),
        .si(si),
        .lnk(lnk)
    );

    // one counter serves every timed operation; only one runs at a time
    fpc_timer #(
        .W(26)
    ) u_tmr (
        .core_clk(core_clk),
        .reset(reset),
        .load(t_load),
        .value(t_val),
        .done(t_done),
        .remaining(t_rem)
    );

    // frame end seen through the synchroniser; shifter words are quiet by then
    assign cs_rise = q.cs_s && !q.cs_p;
    assign len8 = (lnk.nbits == `FPC_OP_BITS);
    assign len72 = (lnk.nbits == `FPC_FRAME_BITS);
    assign pw_mode = !sector_protection_config_reg[`FPC_SPC_PW_MODE];
    assign bp_vol = config_reg_one[`FPC_CFG_BP_VOL];

    // next-state logic for the whole core
    always_comb begin
        d = q;
        t_load = 1'b0;
        t_val = 26'h0000000;
        // two-flop synchronisers, edge detect reads the second stage and its delayed copy
        d.cs_m = cs_n;
        d.cs_s = q.cs_m;
        d.cs_p = q.cs_s;
        d.hr_m = hw_reset_pin_n;
        d.hr_s = q.hr_m;

        // timed operation ends
        if (t_done) begin
            unique case (q.st)
                st_pwprog: begin
                    d.perr = q.perr | op_fail;
                    d.wen = 1'b0;
                    d.st = st_idle;
                end
                st_unlock: begin
                    if (q.match) begin
                        d.lock = 1'b1;
                        d.st = st_idle;
                    end else begin
                        d.perr = 1'b1;
                        d.st = st_unlock_fail;
                    end
                end
                st_program: begin
                    d.perr = q.perr | op_fail;
                    d.wen = 1'b0;
                    d.st = st_idle;
                end
                st_erase: begin
                    d.eerr = q.eerr | op_fail;
                    d.wen = 1'b0;
                    d.st = st_idle;
                end
                st_suspend: begin
                    // suspended op parks; busy drops here
                    d.psusp = !q.is_ers;
                    d.esusp = q.is_ers;
                    d.st = st_idle;
                end
                default: begin
                    d.st = st_idle; // recovery over
                end
            endcase
        end

        // array operations started by the program/erase command logic
        if (q.st == st_idle && !q.psusp && !q.esusp && q.wen && !cs_rise) begin
            if (prog_start) begin
                d.st = st_program;
                d.is_ers = 1'b0;
                t_load = 1'b1;
                t_val = PROGRAM_CYC;
            end else if (erase_start) begin
                d.st = st_erase;
                d.is_ers = 1'b1;
                t_load = 1'b1;
                t_val = ERASE_CYC;
            end
        end

        // command decode at the end of each frame
        if (cs_rise) begin
            if (q.crd) begin
                // only eight ones get through continuous read
                if (len8 && lnk.opcode == `FPC_OP_MODE_RST) begin
                    d.crd = 1'b0;
                end
            end else if (q.st == st_idle) begin
                unique case (lnk.opcode)
                    `FPC_OP_WR_EN: begin
                        if (len8) begin
                            d.wen = 1'b1;
                        end
                    end
                    `FPC_OP_CLR_STAT: begin
                        if (len8) begin
                            d.perr = 1'b0;
                            d.eerr = 1'b0;
                        end
                    end
                    `FPC_OP_PW_PROG: begin
                        // wrong length, no latch or password mode: dropped
                        if (len72 && q.wen && !pw_mode) begin
                            d.pw = lnk.pw;
                            d.st = st_pwprog;
                            t_load = 1'b1;
                            t_val = PWPROG_CYC;
                        end
                    end
                    `FPC_OP_PW_UNLOCK: begin
                        if (len72) begin
                            // compare now; the shifter may be refilled later
                            d.match = (lnk.pw == q.pw);
                            d.st = st_unlock;
                            t_load = 1'b1;
                            t_val = UNLOCK_CYC;
                        end
                    end
                    `FPC_OP_SW_RST: begin
                        if (len8) begin
                            d.st = st_recover;
                        end
                    end
                    `FPC_OP_MODE_RST: begin
                        if (len8) begin
                            d.crd = 1'b0;
                        end
                    end
                    `FPC_OP_PGM_RES: begin
                        if (len8 && q.psusp) begin
                            d.psusp = 1'b0;
                            d.st = st_program;
                            t_load = 1'b1;
                            t_val = q.rem;
                        end
                    end
                    `FPC_OP_ERS_RES: begin
                        if (len8 && q.esusp) begin
                            d.esusp = 1'b0;
                            d.st = st_erase;
                            t_load = 1'b1;
                            t_val = q.rem;
                        end
                    end
                    default: begin
                        // reads and other commands live elsewhere
                    end
                endcase
            end else if (q.st == st_unlock_fail) begin
                // stuck busy until a recovery command arrives
                if (len8 && lnk.opcode == `FPC_OP_CLR_STAT) begin
                    d.perr = 1'b0;
                    d.st = st_idle;
                end else if (len8 && lnk.opcode == `FPC_OP_SW_RST) begin
                    d.st = st_recover;
                end
            end else if (q.st == st_program || q.st == st_erase) begin
                // suspend keeps what is left so resume does not start over
                if (len8 && ((q.st == st_program && lnk.opcode == `FPC_OP_PGM_SUSP) ||
                    (q.st == st_erase && lnk.opcode == `FPC_OP_ERS_SUSP))) begin
                    d.rem = t_rem;
                    d.st = st_suspend;
                    t_load = 1'b1;
                    t_val = q.is_ers ? 26'(`FPC_ESL_CYC) : 26'(`FPC_PSL_CYC);
                end
            end
            // any other frame while busy is simply dropped
        end

        // software reset body: power-up state bar freeze, lock, stored words and frozen or nonvolatile protect bits
        if (cs_rise && d.st == st_recover && q.st != st_recover) begin
            d.wen = 1'b0;
            d.perr = 1'b0;
            d.eerr = 1'b0;
            d.crd = 1'b0;
            d.psusp = 1'b0;
            d.esusp = 1'b0;
            // frz, lock and pw deliberately untouched
            // config_reg_one is an input and is never written here
            if (bp_vol && !q.frz) begin
                d.bp = 3'h0;
            end
            t_load = 1'b1;
            t_val = RECOVER_CYC;
        end

        // side inputs after the frame logic, so a hardware set beats a same-cycle clear
        if (cont_read_enter) begin
            d.crd = 1'b1;
        end
        if (freeze_set) begin
            d.frz = 1'b1;
        end
        if (bp_wr && !q.frz) begin
            d.bp = bp_wdata;
        end

        // pin reset: everything except the synchronisers, the stored password, is_ers, match and rem
        if (!q.hr_s) begin
            d.st = st_idle;
            d.wen = 1'b0;
            d.perr = 1'b0;
            d.eerr = 1'b0;
            d.lock = !pw_mode;
            d.frz = 1'b0;
            d.crd = 1'b0;
            d.psusp = 1'b0;
            d.esusp = 1'b0;
            d.bp = bp_vol ? 3'h0 : block_protect_nv;
            t_load = 1'b0;
        end
    end

    // core state register; power-on reset brings defaults
    always_ff @(posedge core_clk) begin
        if (reset) begin
            q.st <= st_idle;
            q.wen <= 1'b0;
            q.perr <= 1'b0;
            q.eerr <= 1'b0;
            // password mode powers up locked, otherwise open
            q.lock <= !pw_mode;
            q.frz <= 1'b0;
            q.crd <= 1'b0;
            q.psusp <= 1'b0;
            q.esusp <= 1'b0;
            q.is_ers <= 1'b0;
            q.match <= 1'b0;
            q.bp <= bp_vol ? 3'h0 : block_protect_nv;
            q.pw <= `FPC_PW_RST;
            q.rem <= 26'h0000000;
            q.cs_m <= 1'b1;
            q.cs_s <= 1'b1;
            q.cs_p <= 1'b1;
            q.hr_m <= 1'b1;
            q.hr_s <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // status outputs straight from flops
    assign busy_flag = !(q.st == st_idle);
    assign write_enable_latch = q.wen;
    assign program_error_flag = q.perr;
    assign erase_error_flag = q.eerr;
    assign protect_lock_bit = q.lock;
    assign config_lock_bit = q.frz;
    assign block_protect_bits = q.bp;
    assign cont_read_mode = q.crd;
    assign program_suspended = q.psusp;
    assign erase_suspended = q.esusp;
endmodule : fpc_top
`default_nettype wire

/* File: dv/fpc_host_model.sv */
// serial host model: shifts command frames into the flash command block
// assumes the bench calls xfer and leaves chip select high between frames
`timescale 1ns/1ps
`default_nettype none
module fpc_host_model (
    output logic sck,
    output logic cs_n,
    output logic si
);
    // idle: clock parked low, no frame
    // a real select rise after time zero arms the shifter's frame marker
    initial begin
        sck = 1'b0;
        cs_n = 1'b0;
        si = 1'b0;
        #1 cs_n = 1'b1;
    end
    // send the first n bits of v, msb first, 64 ns serial period
    task automatic xfer(input logic [71:0] v, input int n);
        cs_n = 1'b0;
        #40;
        for (int i = 0; i < n; i++) begin
            si = v[71-i];
            #32 sck = 1'b1;
            #32 sck = 1'b0;
        end
        #20 cs_n = 1'b1;
        si = ~si; // released line must not look held
        #200; // high time well above three core clocks
    endtask : xfer
endmodule : fpc_host_model
`default_nettype wire

/* File: dv/fpc_top_props.sv */
// port-level checks of the password/reset command block
// assumes a bind onto fpc_top with the core clock as sampling clock
`timescale 1ns/1ps
`default_nettype none
module fpc_top_props (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic hw_reset_pin_n,
    input wire logic prog_start,
    input wire logic erase_start,
    input wire logic busy_flag,
    input wire logic write_enable_latch,
    input wire logic program_error_flag,
    input wire logic protect_lock_bit,
    input wire logic config_lock_bit,
    input wire logic [2:0] block_protect_bits,
    input wire logic program_suspended,
    input wire logic erase_suspended
);
    logic [3:0] pin_h; // recent pin samples, covers the sync latency
    logic pin_any; // a pin reset may be acting now
    // shift history of the reset pin
    always_ff @(posedge core_clk) begin
        pin_h <= {pin_h[2:0], hw_reset_pin_n};
    end
    assign pin_any = !hw_reset_pin_n || !(&pin_h);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    AST_RST_CLEAR: assert property (disable iff (1'b0) reset |=> !busy_flag && !write_enable_latch && !program_error_flag)
        else $error("flags not cleared by reset");
    AST_PERR_CAUSE: assert property ($rose(program_error_flag) |-> $past(busy_flag))
        else $error("error flag rose outside an operation");
    AST_LOCK_RISE: assert property ($rose(protect_lock_bit) |-> $fell(busy_flag) || pin_any)
        else $error("lock bit rose outside unlock end");
    AST_LOCK_KEEP: assert property ($fell(protect_lock_bit) |-> pin_any)
        else $error("lock bit cleared without hard reset");
    AST_FRZ_KEEP: assert property ($fell(config_lock_bit) |-> pin_any)
        else $error("freeze bit cleared without hard reset");
    AST_BP_FROZEN: assert property (config_lock_bit && $past(config_lock_bit) |-> $stable(block_protect_bits) || pin_any)
        else $error("protect bits changed while frozen");
    AST_PSUSP: assert property ($rose(program_suspended) |-> !busy_flag ##1 !busy_flag)
        else $error("busy during program suspend");
    AST_ESUSP: assert property ($rose(erase_suspended) |-> !busy_flag && !program_suspended)
        else $error("busy during erase suspend");
    AST_BUSY_CAUSE: assert property ($rose(busy_flag) |-> $past(prog_start) || $past(erase_start) || ($past(cs_n) && $past(cs_n, 2)))
        else $error("busy rose without a cause");
endmodule : fpc_top_props
bind fpc_top fpc_top_props u_props (.core_clk(core_clk), .reset(reset), .cs_n(cs_n),
    .hw_reset_pin_n(hw_reset_pin_n), .prog_start(prog_start), .erase_start(erase_start),
    .busy_flag(busy_flag), .write_enable_latch(write_enable_latch),
    .program_error_flag(program_error_flag), .protect_lock_bit(protect_lock_bit),
    .config_lock_bit(config_lock_bit), .block_protect_bits(block_protect_bits),
    .program_suspended(program_suspended), .erase_suspended(erase_suspended));
`default_nettype wire

/* File: dv/test_fpc_top.sv */
// self-checking bench of the password/reset command block
// assumes short operation counts; serial frames come from the host model
`timescale 1ns/1ps
`default_nettype none
`include "fpc_cfg.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; $display("mismatch at %0t: got %h exp %h", $time, (a), (e)); end end
module test_fpc_top;
    import fpc_pkg::*;
    typedef struct {logic [7:0] op; int n; logic wen;} fpc_row_t; // frame and latch after it
    localparam logic [63:0] PW = 64'h0123_4567_89ab_cdef; // stored password
    logic core_clk, reset, hw_n, op_fail, prog_start, erase_start, cre, bp_wr, freeze_set;
    logic [15:0] spc;
    logic [7:0] cfg1;
    logic [2:0] nvb, bpw, bp;
    logic busy, wen, perr, eerr, lock, frz, crd, psusp, esusp;
    wire sck, cs_n, si;
    int errors = 0;
    int cmp_count = 0;
    int c;
    fpc_row_t rows[7] = '{'{8'h06, 8, 1'b1}, '{8'he8, 71, 1'b1}, '{8'he8, 72, 1'b0},
        '{8'he8, 72, 1'b0}, '{8'h06, 7, 1'b0}, '{8'h06, 9, 1'b0}, '{8'h06, 8, 1'b1}};
    fpc_host_model u_host (.sck(sck), .cs_n(cs_n), .si(si));
    fpc_top #(.PWPROG_CYC(26'd20), .UNLOCK_CYC(26'd20), .RECOVER_CYC(26'd20),
        .PROGRAM_CYC(26'd2000), .ERASE_CYC(26'd2000)) u_dut (.core_clk(core_clk), .reset(reset),
        .sck(sck), .cs_n(cs_n), .si(si), .hw_reset_pin_n(hw_n), .sector_protection_config_reg(spc),
        .config_reg_one(cfg1), .block_protect_nv(nvb), .op_fail(op_fail), .prog_start(prog_start),
        .erase_start(erase_start), .cont_read_enter(cre), .bp_wr(bp_wr), .bp_wdata(bpw),
        .freeze_set(freeze_set), .busy_flag(busy), .write_enable_latch(wen),
        .program_error_flag(perr), .erase_error_flag(eerr), .protect_lock_bit(lock),
        .config_lock_bit(frz), .block_protect_bits(bp), .cont_read_mode(crd),
        .program_suspended(psusp), .erase_suspended(esusp));
    // 20 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // print counts and verdict, then stop
    task end_of_test;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // opcode then password bytes, low byte first
    task send(input logic [7:0] op, input logic [63:0] pw, input int n);
        logic [63:0] pw_sw; // password with its bytes reversed
        pw_sw = {<<8{pw}};
        u_host.xfer({op, pw_sw}, n);
        repeat (2) @(negedge core_clk);
    endtask : send
    // bounded wait for busy to drop; c holds cycles waited
    task idle;
        c = 0;
        while (busy !== 1'b0 && c < 5000) begin
            @(negedge core_clk);
            c++;
        end
        if (c >= 5000) errors++;
    endtask : idle
    // hang guard, well beyond the expected run
    initial begin
        #3_000_000;
        errors++;
        end_of_test();
    end
    // main sequence
    initial begin
        {reset, hw_n, op_fail, prog_start, erase_start, cre, bp_wr, freeze_set} = 8'h c0;
        spc = 16'hffff;
        cfg1 = 8'h08;
        nvb = 3'h5;
        bpw = 3'h0;
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        `CHK(bp, 3'h0)
        foreach (rows[i]) begin
            send(rows[i].op, PW, rows[i].n);
            idle();
            `CHK({wen, perr, busy}, {rows[i].wen, 2'b00})
        end
        op_fail = 1'b1;
        send(`FPC_OP_PW_PROG, PW, 72);
        `CHK(busy, 1'b1)
        idle();
        `CHK(c <= 20, 1'b1)
        `CHK({wen, perr}, 2'b01)
        op_fail = 1'b0;
        send(`FPC_OP_CLR_STAT, PW, 8);
        `CHK(perr, 1'b0)
        spc[2] = 1'b0;
        send(`FPC_OP_WR_EN, PW, 8);
        send(`FPC_OP_PW_PROG, ~PW, 72);
        `CHK({busy, wen}, 2'b01)
        hw_n = 1'b0;
        repeat (4) @(negedge core_clk);
        hw_n = 1'b1;
        repeat (4) @(negedge core_clk);
        `CHK(lock, 1'b0)
        send(`FPC_OP_PW_UNLOCK, ~PW, 72);
        repeat (40) @(negedge core_clk);
        `CHK({busy, perr}, 2'b11)
        send(`FPC_OP_WR_EN, PW, 8);
        `CHK(wen, 1'b0)
        send(`FPC_OP_CLR_STAT, PW, 8);
        `CHK({busy, perr}, 2'b00)
        send(`FPC_OP_PW_UNLOCK, PW, 71);
        repeat (30) @(negedge core_clk);
        `CHK({busy, lock}, 2'b00)
        send(`FPC_OP_PW_UNLOCK, PW, 72);
        `CHK(busy, 1'b1)
        idle();
        `CHK(lock, 1'b1)
        bpw = 3'h3;
        bp_wr = 1'b1;
        @(negedge core_clk) bp_wr = 1'b0;
        send(`FPC_OP_PW_UNLOCK, ~PW, 72);
        repeat (40) @(negedge core_clk);
        send(`FPC_OP_MODE_RST, PW, 8);
        send(`FPC_OP_SW_RST, PW, 8);
        `CHK(busy, 1'b1)
        idle();
        `CHK({perr, lock, bp}, 5'b01000)
        bpw = 3'h6;
        bp_wr = 1'b1;
        @(negedge core_clk) {bp_wr, freeze_set} = 2'b01;
        @(negedge core_clk) freeze_set = 1'b0;
        send(`FPC_OP_SW_RST, PW, 8);
        idle();
        `CHK({frz, bp}, 4'he)
        cre = 1'b1;
        @(negedge core_clk) cre = 1'b0;
        send(`FPC_OP_WR_EN, PW, 8);
        `CHK({crd, wen}, 2'b10)
        send(`FPC_OP_MODE_RST, PW, 8);
        send(`FPC_OP_WR_EN, PW, 8);
        `CHK({crd, wen}, 2'b01)
        prog_start = 1'b1;
        @(negedge core_clk) prog_start = 1'b0;
        repeat (100) @(negedge core_clk);
        send(`FPC_OP_PGM_SUSP, PW, 8);
        idle();
        `CHK({c <= 800, psusp}, 2'b11)
        repeat (100) @(negedge core_clk);
        send(`FPC_OP_PGM_RES, PW, 8);
        `CHK({busy, psusp}, 2'b10)
        idle();
        send(`FPC_OP_WR_EN, PW, 8);
        erase_start = 1'b1;
        @(negedge core_clk) erase_start = 1'b0;
        repeat (100) @(negedge core_clk);
        send(`FPC_OP_ERS_SUSP, PW, 8);
        idle();
        `CHK({c <= 900, esusp}, 2'b11)
        send(`FPC_OP_ERS_RES, PW, 8);
        `CHK(busy, 1'b1)
        idle();
        `CHK({c <= 2000, esusp, eerr}, 3'b100)
        reset = 1'b1;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        `CHK({busy, wen, perr, frz}, 4'h0)
        end_of_test();
    end
endmodule : test_fpc_top
`default_nettype wire
